/* File: cfg_smi_pkg.sv */
// package: configuration port and management interrupt constants
// Behaviour
// - hard or power-on reset leaves run state, all logical devices disabled
// - index and data ports answer only in configuration state
// - strap caught at reset release: low gives 0x03f0, high 0x0370
// - index port at config address, data port one above it
// - software relocates config base via low and high address registers
// - key 0x55 on config port enters configuration state
// - key 0xaa on config port returns to run state
// - every port decode qualified by aen low
// - group request is or of eight enabled source requests
// - source enables held at indices b4 and b5 of device 8
// - group request reaches pin only while enable two bit 7 set
// - enable two bit routes keyboard aux output a onto pin
// - status bits set on events regardless of enables, read b6 b7
// - smi registers reachable in config state and via run-time pair
package cfg_smi_pkg;
   localparam logic [15:0] CFG_BASE_STRAP_LOW  = 16'h03f0;
   localparam logic [15:0] CFG_BASE_STRAP_HIGH = 16'h0370;
   localparam logic [15:0] DATA_PORT_STEP      = 16'h0001;
   localparam logic [7:0]  KEY_ENTER           = 8'h55;
   localparam logic [7:0]  KEY_EXIT            = 8'haa;
   localparam logic [7:0]  IDX_LDN             = 8'h07;
   localparam logic [7:0]  IDX_ADDR_LOW        = 8'h26;
   localparam logic [7:0]  IDX_ADDR_HIGH       = 8'h27;
   localparam logic [7:0]  IDX_ACTIVATE        = 8'h30;
   localparam logic [7:0]  IDX_SMI_EN_ONE      = 8'hb4;
   localparam logic [7:0]  IDX_SMI_EN_TWO      = 8'hb5;
   localparam logic [7:0]  IDX_SMI_ST_ONE      = 8'hb6;
   localparam logic [7:0]  IDX_SMI_ST_TWO      = 8'hb7;
   localparam logic [7:0]  LDN_SMI             = 8'h08;
   localparam logic [3:0]  LDN_COUNT           = 4'h9;
   localparam logic [7:0]  RESET_ZERO          = 8'h00;
   // run-time index/data pair, offsets from runtime_base
   localparam logic [15:0] RT_INDEX_OFS        = 16'h0000;
   localparam logic [15:0] RT_DATA_OFS         = 16'h0001;
   localparam logic [15:0] RT_BASE_DEFAULT     = 16'h0400;
   // runtime indices 0..3 select the four smi registers
   localparam logic [1:0]  RT_SEL_EN_ONE       = 2'h0;
   localparam logic [1:0]  RT_SEL_EN_TWO       = 2'h1;
   localparam logic [1:0]  RT_SEL_ST_ONE       = 2'h2;
   localparam logic [1:0]  RT_SEL_ST_TWO       = 2'h3;
   // enable one bit layout
   localparam int EN1_PAR      = 0;
   localparam int EN1_SER_B    = 1;
   localparam int EN1_SER_A    = 2;
   localparam int EN1_FLOPPY   = 3;
   localparam int EN1_WATCHDOG = 4;
   // enable two bit layout
   localparam int EN2_MOUSE    = 0;
   localparam int EN2_KEYBOARD = 1;
   localparam int EN2_INFRARED = 2;
   localparam int EN2_AUX_ROUTE = 3;
   localparam int EN2_PIN_EN   = 7;
   localparam logic [7:0] EN1_MASK = 8'h1f;
   localparam logic [7:0] EN2_MASK = 8'h8f;
   localparam logic [7:0] ST1_MASK = 8'h1f;
   localparam logic [7:0] ST2_MASK = 8'h07;
   typedef enum logic {RUN_STATE, CONFIG_STATE} cfg_state_t;
endpackage

/* File: cfg_smi.sv */
// module: configuration port decoder, register bank and management interrupt
`timescale 1ns/1ps
module cfg_smi
   import cfg_smi_pkg::*;
   #(parameter logic [15:0] RT_BASE = RT_BASE_DEFAULT)
   (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        strap_base_sel,
   input  wire logic [15:0] io_addr,
   input  wire logic        io_aen,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   input  wire logic [7:0]  io_wdata,
   output logic      [7:0]  io_rdata,
   output logic             io_rd_hit,
   input  wire logic        par_port_req,
   input  wire logic        serial_b_req,
   input  wire logic        serial_a_req,
   input  wire logic        floppy_req,
   input  wire logic        watchdog_req,
   input  wire logic        mouse_req,
   input  wire logic        keyboard_req,
   input  wire logic        infrared_req,
   input  wire logic        kbc_aux_output_a,
   output logic             mgmt_irq_out_n,
   output logic      [8:0]  ldev_active,
   output logic             cfg_mode
   );

   cfg_state_t  state;
   logic        strap_pending;
   logic [15:0] cfg_base;
   logic [7:0]  index_reg;
   logic [7:0]  ldn;
   logic [1:0]  rt_index;
   logic [7:0]  smi_source_enable_one;
   logic [7:0]  smi_source_enable_two;
   logic [7:0]  smi_event_status_one;
   logic [7:0]  smi_event_status_two;
   logic        hit_cfg;
   logic        hit_data;
   logic        hit_rt_idx;
   logic        hit_rt_data;
   logic        in_cfg;
   logic        smi_sel;
   logic [7:0]  next_rdata;
   logic        next_hit;
   logic        group_req;
   logic [7:0]  ev_one;
   logic [7:0]  ev_two;
   logic        ldn_valid;
   logic        wr_index;
   logic        wr_ldn;
   logic        wr_addr_low;
   logic        wr_addr_high;
   logic        wr_activate;
   logic        wr_rt_index;
   logic        wr_en_one;
   logic        wr_en_two;
   logic        wr_st_one;
   logic        wr_st_two;
   logic        pin_low;

   function automatic logic port_match(input logic [15:0] a,
                                       input logic [15:0] p,
                                       input logic        aen);
      port_match = !aen && (a == p);
   endfunction

   // smi register reached through the config data port or the run-time pair
   function automatic logic smi_pick(input logic       cfg_hit,
                                     input logic [7:0] cfg_index,
                                     input logic [7:0] cfg_want,
                                     input logic       rt_hit,
                                     input logic [1:0] rt_sel,
                                     input logic [1:0] rt_want);
      smi_pick = (cfg_hit && cfg_index == cfg_want) || (rt_hit && rt_sel == rt_want);
   endfunction

   assign in_cfg      = (state == CONFIG_STATE);
   assign cfg_mode    = in_cfg;
   assign hit_cfg     = port_match(io_addr, cfg_base, io_aen);
   assign hit_data    = in_cfg &&
                        port_match(io_addr, 16'(cfg_base + DATA_PORT_STEP), io_aen);
   assign hit_rt_idx  = !in_cfg &&
                        port_match(io_addr, 16'(RT_BASE + RT_INDEX_OFS), io_aen);
   assign hit_rt_data = !in_cfg &&
                        port_match(io_addr, 16'(RT_BASE + RT_DATA_OFS), io_aen);
   assign smi_sel     = (ldn == LDN_SMI);

   // write strobes, one per register
   assign ldn_valid    = (ldn < 8'(LDN_COUNT));
   assign wr_index     = io_wr && hit_cfg && in_cfg && io_wdata != KEY_EXIT;
   assign wr_ldn       = io_wr && hit_data && index_reg == IDX_LDN;
   assign wr_addr_low  = io_wr && hit_data && index_reg == IDX_ADDR_LOW;
   assign wr_addr_high = io_wr && hit_data && index_reg == IDX_ADDR_HIGH;
   assign wr_activate  = io_wr && hit_data && index_reg == IDX_ACTIVATE && ldn_valid;
   assign wr_rt_index  = io_wr && hit_rt_idx;
   assign wr_en_one    = io_wr && smi_pick(hit_data && smi_sel, index_reg, IDX_SMI_EN_ONE,
                                           hit_rt_data, rt_index, RT_SEL_EN_ONE);
   assign wr_en_two    = io_wr && smi_pick(hit_data && smi_sel, index_reg, IDX_SMI_EN_TWO,
                                           hit_rt_data, rt_index, RT_SEL_EN_TWO);
   assign wr_st_one    = io_wr && smi_pick(hit_data && smi_sel, index_reg, IDX_SMI_ST_ONE,
                                           hit_rt_data, rt_index, RT_SEL_ST_ONE);
   assign wr_st_two    = io_wr && smi_pick(hit_data && smi_sel, index_reg, IDX_SMI_ST_TWO,
                                           hit_rt_data, rt_index, RT_SEL_ST_TWO);

   // key handling and configuration state
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= RUN_STATE;
      end else if (io_wr && hit_cfg) begin
         case (state)
            RUN_STATE: begin
               if (io_wdata == KEY_ENTER) begin
                  state <= CONFIG_STATE;
               end
            end
            CONFIG_STATE: begin
               if (io_wdata == KEY_EXIT) begin
                  state <= RUN_STATE;
               end
            end
            default: begin
               state <= RUN_STATE;
            end
         endcase
      end
   end

   // strap is taken on the first edge after reset release
   always_ff @(posedge clk) begin
      if (srst) begin
         strap_pending <= 1'b1;
      end else begin
         strap_pending <= 1'b0;
      end
   end

   // config base: strap choice, then software relocation
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_base <= CFG_BASE_STRAP_LOW;
      end else if (strap_pending) begin
         cfg_base <= strap_base_sel ? CFG_BASE_STRAP_HIGH : CFG_BASE_STRAP_LOW;
      end else if (wr_addr_low) begin
         cfg_base[7:0] <= io_wdata;
      end else if (wr_addr_high) begin
         cfg_base[15:8] <= io_wdata;
      end
   end

   // index register; the exit key never loads it
   always_ff @(posedge clk) begin
      if (srst) begin
         index_reg <= RESET_ZERO;
      end else if (wr_index) begin
         index_reg <= io_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ldn <= RESET_ZERO;
      end else if (wr_ldn) begin
         ldn <= io_wdata;
      end
   end

   // per-device activate bits
   always_ff @(posedge clk) begin
      if (srst) begin
         ldev_active <= '0;
      end else if (wr_activate) begin
         ldev_active[ldn[3:0]] <= io_wdata[0];
      end
   end

   // run-time index register
   always_ff @(posedge clk) begin
      if (srst) begin
         rt_index <= RT_SEL_EN_ONE;
      end else if (wr_rt_index) begin
         rt_index <= io_wdata[1:0];
      end
   end

   // smi enable registers
   always_ff @(posedge clk) begin
      if (srst) begin
         smi_source_enable_one <= RESET_ZERO;
      end else if (wr_en_one) begin
         smi_source_enable_one <= io_wdata & EN1_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         smi_source_enable_two <= RESET_ZERO;
      end else if (wr_en_two) begin
         smi_source_enable_two <= io_wdata & EN2_MASK;
      end
   end

   // event capture, sticky until written as one; set wins over clear
   assign ev_one = {3'h0, watchdog_req, floppy_req, serial_a_req, serial_b_req, par_port_req};
   assign ev_two = {5'h00, infrared_req, keyboard_req, mouse_req};

   always_ff @(posedge clk) begin
      if (srst) begin
         smi_event_status_one <= RESET_ZERO;
      end else if (wr_st_one) begin
         smi_event_status_one <= ((smi_event_status_one & ~io_wdata) | ev_one) & ST1_MASK;
      end else begin
         smi_event_status_one <= (smi_event_status_one | ev_one) & ST1_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         smi_event_status_two <= RESET_ZERO;
      end else if (wr_st_two) begin
         smi_event_status_two <= ((smi_event_status_two & ~io_wdata) | ev_two) & ST2_MASK;
      end else begin
         smi_event_status_two <= (smi_event_status_two | ev_two) & ST2_MASK;
      end
   end

   // group request and pin
   assign group_req =
      (smi_source_enable_one[EN1_PAR]      && par_port_req) ||
      (smi_source_enable_one[EN1_SER_B]    && serial_b_req) ||
      (smi_source_enable_one[EN1_SER_A]    && serial_a_req) ||
      (smi_source_enable_one[EN1_FLOPPY]   && floppy_req)   ||
      (smi_source_enable_one[EN1_WATCHDOG] && watchdog_req) ||
      (smi_source_enable_two[EN2_MOUSE]    && mouse_req)    ||
      (smi_source_enable_two[EN2_KEYBOARD] && keyboard_req) ||
      (smi_source_enable_two[EN2_INFRARED] && infrared_req);

   // pin pulled low by the gated group request or by the routed aux output
   assign pin_low = (smi_source_enable_two[EN2_PIN_EN] && group_req) ||
                    (smi_source_enable_two[EN2_AUX_ROUTE] && !kbc_aux_output_a);

   always_ff @(posedge clk) begin
      if (srst) begin
         mgmt_irq_out_n <= 1'b1;
      end else begin
         mgmt_irq_out_n <= !pin_low;
      end
   end

   // read mux
   always_comb begin
      next_rdata = RESET_ZERO;
      next_hit   = 1'b0;
      if (io_rd && hit_cfg && in_cfg) begin
         next_hit   = 1'b1;
         next_rdata = index_reg;
      end else if (io_rd && hit_data) begin
         next_hit = 1'b1;
         case (index_reg)
            IDX_LDN:       next_rdata = ldn;
            IDX_ADDR_LOW:  next_rdata = cfg_base[7:0];
            IDX_ADDR_HIGH: next_rdata = cfg_base[15:8];
            IDX_ACTIVATE: begin
               if (ldn_valid) begin
                  next_rdata = {7'h00, ldev_active[ldn[3:0]]};
               end
            end
            IDX_SMI_EN_ONE: begin
               if (smi_sel) begin
                  next_rdata = smi_source_enable_one;
               end
            end
            IDX_SMI_EN_TWO: begin
               if (smi_sel) begin
                  next_rdata = smi_source_enable_two;
               end
            end
            IDX_SMI_ST_ONE: begin
               if (smi_sel) begin
                  next_rdata = smi_event_status_one;
               end
            end
            IDX_SMI_ST_TWO: begin
               if (smi_sel) begin
                  next_rdata = smi_event_status_two;
               end
            end
            default:       next_rdata = RESET_ZERO;
         endcase
      end else if (io_rd && hit_rt_idx) begin
         next_hit   = 1'b1;
         next_rdata = {6'h00, rt_index};
      end else if (io_rd && hit_rt_data) begin
         next_hit = 1'b1;
         case (rt_index)
            RT_SEL_EN_ONE: next_rdata = smi_source_enable_one;
            RT_SEL_EN_TWO: next_rdata = smi_source_enable_two;
            RT_SEL_ST_ONE: next_rdata = smi_event_status_one;
            RT_SEL_ST_TWO: next_rdata = smi_event_status_two;
            default:       next_rdata = RESET_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         io_rdata  <= RESET_ZERO;
         io_rd_hit <= 1'b0;
      end else begin
         io_rdata  <= next_rdata;
         io_rd_hit <= next_hit;
      end
   end
endmodule

/* File: cfg_smi_chk.sv */
// checker: port-level assertions for the configuration port and management interrupt
`timescale 1ns/1ps
module cfg_smi_chk
   import cfg_smi_pkg::*;
   (
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       io_aen,
   input wire logic       io_wr,
   input wire logic       io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic       io_rd_hit,
   input wire logic       par_port_req,
   input wire logic       serial_b_req,
   input wire logic       serial_a_req,
   input wire logic       floppy_req,
   input wire logic       watchdog_req,
   input wire logic       mouse_req,
   input wire logic       keyboard_req,
   input wire logic       infrared_req,
   input wire logic       kbc_aux_output_a,
   input wire logic       mgmt_irq_out_n,
   input wire logic [8:0] ldev_active,
   input wire logic       cfg_mode
   );
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   wire logic any_req = par_port_req | serial_b_req | serial_a_req | floppy_req
                        | watchdog_req | mouse_req | keyboard_req | infrared_req;
   reset_quiet_a: assert property (disable iff (1'b0) srst |=> mgmt_irq_out_n && !cfg_mode
      && ldev_active == 9'h000 && !io_rd_hit) else $error("state not clear after reset");
   stay_run_a: assert property (!cfg_mode && !(io_wr && !io_aen && io_wdata == KEY_ENTER)
      |=> !cfg_mode) else $error("left run state without entry key");
   stay_cfg_a: assert property (cfg_mode && !(io_wr && !io_aen && io_wdata == KEY_EXIT)
      |=> cfg_mode) else $error("left config state without exit key");
   aen_write_a: assert property (io_wr && io_aen |=> $stable(cfg_mode)
      && $stable(ldev_active)) else $error("write decoded with aen high");
   aen_read_a: assert property (io_rd && io_aen |=> !io_rd_hit)
      else $error("read decoded with aen high");
   idle_read_a: assert property (!io_rd |=> !io_rd_hit && io_rdata == 8'h00)
      else $error("read answer without read");
   run_ldev_a: assert property (!cfg_mode |=> $stable(ldev_active))
      else $error("activation changed in run state");
   quiet_irq_a: assert property (!any_req && kbc_aux_output_a |=> mgmt_irq_out_n)
      else $error("interrupt pin low with no request");
   cover property ($rose(cfg_mode));
   cover property ($fell(mgmt_irq_out_n));
   cover property (io_rd_hit);
endmodule
bind cfg_smi cfg_smi_chk i_chk (.*);

/* File: isa_host.sv */
// host bus model: one-cycle write and read strobes on the i/o bus
`timescale 1ns/1ps
module isa_host (
   input  wire logic        clk,
   output logic      [15:0] io_addr,
   output logic             io_aen,
   output logic             io_wr,
   output logic             io_rd,
   output logic      [7:0]  io_wdata,
   input  wire logic [7:0]  io_rdata,
   input  wire logic        io_rd_hit
   );
   initial begin
      io_addr = 16'h0000;
      io_aen = 1'b0;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic dma);
      @(posedge clk);
      io_addr <= a;
      io_wdata <= d;
      io_aen <= dma;
      io_wr <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
      io_aen <= 1'b0;
      io_wdata <= ~d;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic h,
                     input logic dma);
      @(posedge clk);
      io_addr <= a;
      io_aen <= dma;
      io_rd <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      io_aen <= 1'b0;
      #1;
      d = io_rdata;
      h = io_rd_hit;
   endtask
endmodule

/* File: config_port_and_smi_aggregator_tb.sv */
// testbench: key sequences, register access and interrupt aggregation
`timescale 1ns/1ps
module config_port_and_smi_aggregator_tb;
   import cfg_smi_pkg::*;
   logic clk = 1'b0, srst = 1'b1, strap = 1'b0, aux = 1'b1, hit, io_aen, io_wr, io_rd, rh;
   logic [7:0] src = 8'h00, v, d, io_wdata, io_rdata;
   logic [15:0] io_addr, base = CFG_BASE_STRAP_LOW;
   logic irq_n, cfg_mode;
   logic [8:0] ldev_active;
   int n_fail = 0, n_tests = 0;
   initial forever #2 clk = ~clk;
   isa_host h (.clk(clk), .io_addr(io_addr), .io_aen(io_aen), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_hit(rh));
   cfg_smi i_dut (.clk(clk), .srst(srst), .strap_base_sel(strap), .io_addr(io_addr),
      .io_aen(io_aen), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .io_rd_hit(rh), .par_port_req(src[0]), .serial_b_req(src[1]), .serial_a_req(src[2]),
      .floppy_req(src[3]), .watchdog_req(src[4]), .mouse_req(src[5]), .keyboard_req(src[6]),
      .infrared_req(src[7]), .kbc_aux_output_a(aux), .mgmt_irq_out_n(irq_n),
      .ldev_active(ldev_active), .cfg_mode(cfg_mode));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rst(input logic s);
      @(posedge clk);
      srst <= 1'b1;
      strap <= s;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      base = s ? CFG_BASE_STRAP_HIGH : CFG_BASE_STRAP_LOW;
   endtask
   task automatic cw(input logic [7:0] i, input logic [7:0] val);
      h.wr(base, i, 1'b0);
      h.wr(base + DATA_PORT_STEP, val, 1'b0);
   endtask
   task automatic cr(input logic [7:0] i, input logic [7:0] exp);
      h.wr(base, i, 1'b0);
      h.rd(base + DATA_PORT_STEP, d, hit, 1'b0);
      chk({15'h0000, hit}, 16'h0001);
      chk({8'h00, d}, {8'h00, exp});
   endtask
   task automatic drive(input logic [7:0] s, input logic a, input logic exp_n);
      @(posedge clk);
      src <= s;
      aux <= a;
      @(posedge clk);
      #1;
      chk({15'h0000, irq_n}, {15'h0000, exp_n});
   endtask
   task automatic complete_run;
      $display("tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      complete_run();
   end
   initial begin
      rst(1'b0);
      chk({7'h00, ldev_active}, 16'h0000);
      h.wr(base + DATA_PORT_STEP, IDX_LDN, 1'b0);
      h.rd(base + DATA_PORT_STEP, d, hit, 1'b0);
      chk({7'h00, hit, d}, 16'h0000);
      h.wr(base, 8'h12, 1'b0);
      h.wr(base, KEY_ENTER, 1'b1);
      chk({15'h0000, cfg_mode}, 16'h0000);
      h.wr(base, KEY_ENTER, 1'b0);
      chk({15'h0000, cfg_mode}, 16'h0001);
      cw(IDX_LDN, LDN_SMI);
      cw(IDX_SMI_EN_ONE, 8'hff);
      cr(IDX_SMI_EN_ONE, EN1_MASK);
      h.rd(base + DATA_PORT_STEP, d, hit, 1'b1);
      chk({7'h00, hit, d}, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         v = 8'h01 << i;
         cw(IDX_SMI_EN_ONE, v & EN1_MASK);
         cw(IDX_SMI_EN_TWO, {1'b1, 4'h0, v[7:5]});
         drive(v, 1'b1, 1'b0);
         drive(8'h00, 1'b1, 1'b1);
      end
      cw(IDX_SMI_EN_TWO, 8'h01);
      drive(8'h20, 1'b1, 1'b1);
      drive(8'h00, 1'b1, 1'b1);
      cw(IDX_SMI_EN_ONE, 8'h00);
      cw(IDX_SMI_EN_TWO, 8'h80);
      cw(IDX_SMI_ST_ONE, 8'hff);
      cw(IDX_SMI_ST_TWO, 8'hff);
      drive(8'h01, 1'b1, 1'b1);
      cr(IDX_SMI_ST_ONE, 8'h01);
      cr(IDX_SMI_ST_TWO, 8'h00);
      cw(IDX_SMI_EN_TWO, 8'h08);
      drive(8'h00, 1'b0, 1'b0);
      cw(IDX_SMI_EN_TWO, 8'h00);
      drive(8'h00, 1'b0, 1'b1);
      drive(8'h00, 1'b1, 1'b1);
      cw(IDX_SMI_EN_ONE, 8'h15);
      cw(IDX_ACTIVATE, 8'h01);
      chk({7'h00, ldev_active}, 16'h0100);
      cw(IDX_ADDR_LOW, 8'h70);
      base = CFG_BASE_STRAP_HIGH;
      cr(IDX_ADDR_LOW, 8'h70);
      h.wr(base, KEY_EXIT, 1'b0);
      chk({15'h0000, cfg_mode}, 16'h0000);
      h.wr(RT_BASE_DEFAULT + RT_INDEX_OFS, {6'h00, RT_SEL_EN_ONE}, 1'b0);
      h.rd(RT_BASE_DEFAULT + RT_DATA_OFS, d, hit, 1'b0);
      chk({8'h00, d}, 16'h0015);
      h.wr(CFG_BASE_STRAP_LOW, KEY_ENTER, 1'b0);
      chk({15'h0000, cfg_mode}, 16'h0000);
      rst(1'b1);
      chk({7'h00, ldev_active}, 16'h0000);
      h.wr(base, KEY_ENTER, 1'b0);
      chk({15'h0000, cfg_mode}, 16'h0001);
      cr(IDX_ADDR_HIGH, 8'h03);
      complete_run();
   end
endmodule
